// ===== design/interrupt_vector_config.sv
// interrupt configuration, vector relocation and address decode
// assumes synchronous inputs, one clock and a one-cycle register port
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module interrupt_vector_config
  import ivc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_EXT-1:0] external_irq_lines_n,
  input wire logic serial_tx_irq,
  input wire logic serial_rx_irq,
  input wire logic timer0_irq,
  input wire logic timer1_irq,
  input wire logic dma0_done_irq,
  input wire logic dma1_done_irq,
  input wire logic program_width_pin,
  input wire logic boot_mode_pin,
  input wire logic vec_req,
  input wire logic vec_reset,
  input wire logic [2:0] vec_src,
  input wire logic vec_trap,
  input wire logic [4:0] vec_trap_num,
  output logic [23:0] vec_addr,
  output logic vec_valid,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  input wire logic [15:0] fetch_rdata,
  input wire logic [31:0] fetch_rdata32,
  output logic fetch_half,
  output logic [31:0] fetch_word,
  output logic fetch_done,
  input wire mem_req_s mem_req,
  output decode_s mem_dec,
  output logic [31:0] strobe_zero_ctl_reset,
  output logic [31:0] strobe_one_ctl_reset,
  output logic dma0_serial_tx_req,
  output logic dma1_serial_rx_req,
  output logic [SRC_N-1:0] irq_pending
);

  logic [31:0] status_q;
  logic [31:0] ie_q;
  logic [31:0] if_q;
  logic [NUM_EXT-1:0] ext_act;
  logic [NUM_EXT-1:0] ext_req;
  logic [31:0] hw_set;
  logic [SRC_N-1:0] src_en;
  logic [23:0] base_addr;
  logic [7:0] voff;
  logic edge_mode;
  fetch_e fetch_q;
  logic [15:0] low_half_q;
  logic [23:0] fetch_addr_q;
  logic io_busy_q;
  decode_s dec_d;

  assign edge_mode = status_q[ST_EDGE_BIT];
  assign ext_act = ~external_irq_lines_n;

  // per-line trigger qualifier; edge mode demands the hold time
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      logic prev_q;
      logic [3:0] hold_q;
      logic armed_q;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_q <= 1'b0;
          hold_q <= 4'h0;
          armed_q <= 1'b0;
        end else if (clk_en) begin
          prev_q <= ext_act[gi];
          if (!ext_act[gi]) begin
            armed_q <= 1'b0;
            hold_q <= 4'h0;
          end else if (!prev_q) begin
            armed_q <= 1'b1;
            hold_q <= 4'h1;
          end else if (armed_q && hold_q < 4'(EDGE_HOLD_CYC)) begin
            hold_q <= hold_q + 4'h1;
          end else begin
            armed_q <= 1'b0;
          end
        end
      end
      // level mode re-fires while active; edge fires once after hold
      assign ext_req[gi] = edge_mode ?
        (armed_q && ext_act[gi] && hold_q == 4'(EDGE_HOLD_CYC))
        : ext_act[gi];
    end
  endgenerate

  // hardware set pattern, each source placed at its own flag position
  always_comb begin
    hw_set = '0;
    hw_set[IF_INT0_BIT +: NUM_EXT] = ext_req;
    hw_set[IF_TX_BIT] = serial_tx_irq;
    hw_set[IF_RX_BIT] = serial_rx_irq;
    hw_set[IF_TMR0_BIT] = timer0_irq;
    hw_set[IF_TMR1_BIT] = timer1_irq;
    hw_set[IF_DMA0_BIT] = dma0_done_irq;
    hw_set[IF_DMA1_BIT] = dma1_done_irq;
  end

  // status register; width flag tracks the pin, not software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STATUS_RESET;
    end else if (clk_en) begin
      if (reg_req.wr && reg_req.addr == ADDR_STATUS) begin
        status_q <= (reg_req.wdata & STATUS_WMASK);
      end
      status_q[ST_PROGRAM_WIDTH_PIN_BIT] <= program_width_pin;
    end
  end

  // enable register: software only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= IRQ_ENABLE_RESET;
    end else if (clk_en && reg_req.wr && reg_req.addr == ADDR_IRQ_ENABLE) begin
      ie_q <= reg_req.wdata;
    end
  end

  // flag register; a hardware set beats a software clear in one cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      if_q <= IRQ_FLAG_RESET;
    end else if (clk_en) begin
      if (reg_req.wr && reg_req.addr == ADDR_IRQ_FLAG) begin
        if_q <= reg_req.wdata | hw_set;
      end else begin
        if_q <= if_q | hw_set;
      end
    end
  end

  // pending sources visible to the cpu sequencer
  assign src_en = {if_q[IF_DMA1_BIT] & ie_q[IF_DMA1_BIT],
                   if_q[IF_DMA0_BIT] & ie_q[IF_DMA0_BIT],
                   if_q[IF_TMR1_BIT] & ie_q[IF_TMR1_BIT],
                   if_q[IF_TMR0_BIT] & ie_q[IF_TMR0_BIT],
                   if_q[IF_RX_BIT] & ie_q[IF_RX_BIT],
                   if_q[IF_TX_BIT] & ie_q[IF_TX_BIT],
                   |(if_q[3:0] & ie_q[3:0]), 1'b0};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= '0;
    end else if (clk_en) begin
      irq_pending <= src_en;
    end
  end

  // serial requests are hardwired to their channels, gated by enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma0_serial_tx_req <= 1'b0;
      dma1_serial_rx_req <= 1'b0;
    end else if (clk_en) begin
      dma0_serial_tx_req <= serial_tx_irq &
        ie_q[IE_DMA0_LSB + IF_TX_BIT];
      dma1_serial_rx_req <= serial_rx_irq &
        ie_q[IE_DMA1_LSB + IF_RX_BIT];
    end
  end

  // base uses the live pointer, so a write governs the next fetch
  assign base_addr = {if_q[IF_PTR_LSB +: PTR_W], 8'h00};

  // vector offset table
  always_comb begin
    voff = 8'h00;
    if (vec_trap) begin
      voff = VOFF_TRAP + {3'b000, vec_trap_num};
    end else begin
      case (vec_src)
        3'd0: voff = VOFF_INT0;
        3'd1: voff = VOFF_INT0 + 8'h01;
        3'd2: voff = VOFF_INT0 + 8'h02;
        3'd3: voff = VOFF_INT0 + 8'h03;
        3'd4: voff = VOFF_TX;
        3'd5: voff = VOFF_RX;
        3'd6: voff = VOFF_TMR0;
        default: voff = VOFF_TMR1;
      endcase
    end
  end

  // vector address: reset fixed, others relocated
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_addr <= RESET_VECTOR;
      vec_valid <= 1'b0;
    end else if (clk_en) begin
      vec_valid <= vec_req | vec_reset;
      if (vec_reset) begin
        vec_addr <= RESET_VECTOR;
      end else if (vec_req) begin
        vec_addr <= base_addr | {16'h0000, voff};
      end
    end
  end

  // instruction fetch assembly for 16- or 32-bit program memory
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_q <= FETCH_IDLE;
      low_half_q <= 16'h0000;
      fetch_word <= 32'h0000_0000;
      fetch_done <= 1'b0;
      fetch_half <= 1'b0;
      fetch_addr_q <= 24'h00_0000;
    end else if (clk_en) begin
      fetch_done <= 1'b0;
      case (fetch_q)
        FETCH_IDLE: begin
          if (fetch_req) begin
            fetch_addr_q <= fetch_addr;
            if (status_q[ST_PROGRAM_WIDTH_PIN_BIT]) begin
              fetch_q <= FETCH_LOW;
              fetch_half <= 1'b0;
            end else begin
              fetch_word <= fetch_rdata32;
              fetch_done <= 1'b1;
            end
          end
        end
        FETCH_LOW: begin
          low_half_q <= fetch_rdata;
          fetch_half <= 1'b1;
          fetch_q <= FETCH_HIGH;
        end
        default: begin
          fetch_word <= {fetch_rdata, low_half_q};
          fetch_done <= 1'b1;
          fetch_half <= 1'b0;
          fetch_q <= FETCH_IDLE;
        end
      endcase
    end
  end

  // strobe control reset values re-registered from the width flag every enabled cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_zero_ctl_reset <= STRB_CTL_W32;
      strobe_one_ctl_reset <= STRB_CTL_W32;
    end else if (clk_en) begin
      strobe_zero_ctl_reset <= status_q[ST_PROGRAM_WIDTH_PIN_BIT] ?
        STRB_CTL_W16 : STRB_CTL_W32;
      strobe_one_ctl_reset <= status_q[ST_PROGRAM_WIDTH_PIN_BIT] ?
        STRB_CTL_W16 : STRB_CTL_W32;
    end
  end

  // address decode; boot mode maps the low 4k to internal rom
  always_comb begin
    dec_d = '0;
    dec_d.region = REG_NONE;
    if (!mem_req.valid) begin
      dec_d = '0;
    end else if (boot_mode_pin && mem_req.addr <= BOOT_ROM_END) begin
      dec_d.strobe_zero = 1'b0;
    end else if (mem_req.addr >= PERIPH_BASE &&
                 mem_req.addr <= PERIPH_END) begin
      dec_d.periph = 1'b1;
      if (mem_req.addr >= PERIPH_RSVD_HI ||
          (mem_req.addr >= PERIPH_RSVD_LO && mem_req.addr < PERIPH_XPORT)) begin
        dec_d.reserved = 1'b1;
      end else begin
        dec_d.region = region_e'(3'(mem_req.addr[6:4]) + 3'd1);
        if (mem_req.addr >= PERIPH_XPORT) dec_d.region = REG_XPORT;
      end
    end else if (mem_req.addr >= IO_BASE && mem_req.addr <= IO_END) begin
      dec_d.io = 1'b1;
    end else if (mem_req.addr >= STROBE_ONE_BASE) begin
      dec_d.strobe_one = 1'b1;
    end else begin
      dec_d.strobe_zero = 1'b1;
    end
  end

  // io strobe stretched to two cycles for slow peripherals
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_dec <= '0;
      io_busy_q <= 1'b0;
    end else if (clk_en) begin
      if (io_busy_q) begin
        io_busy_q <= 1'b0;
      end else begin
        mem_dec <= dec_d;
        io_busy_q <= dec_d.io;
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_req.rd) begin
        if (reg_req.addr == ADDR_STATUS) reg_rdata <= status_q;
        else if (reg_req.addr == ADDR_IRQ_ENABLE) reg_rdata <= ie_q;
        else if (reg_req.addr == ADDR_IRQ_FLAG) reg_rdata <= if_q;
        else reg_rdata <= {8'h00, base_addr};
      end
    end
  end

  chk_status_reset: assert property (@(posedge core_clk)
    $rose(rst_n) |-> status_q == STATUS_RESET)
    else $error("status not cleared at reset");
  chk_program_width_pin_follow: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_en |=> status_q[ST_PROGRAM_WIDTH_PIN_BIT] == $past(program_width_pin))
    else $error("width flag does not track pin");
  chk_reset_vector: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && vec_reset) |=> vec_addr == RESET_VECTOR && vec_valid)
    else $error("reset vector not at zero");
  chk_vector_base: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && vec_req && !vec_reset) |=>
      vec_addr[7:0] == $past(voff) &&
      vec_addr[23:8] == $past(if_q[IF_PTR_LSB +: PTR_W]))
    else $error("vector base or offset wrong");
  sequence s_half_fetch;
    clk_en && fetch_q == FETCH_IDLE && fetch_req && status_q[ST_PROGRAM_WIDTH_PIN_BIT]
      ##1 clk_en ##1 clk_en;
  endsequence
  chk_half_fetch: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_half_fetch |=> fetch_done)
    else $error("16-bit fetch not two reads");
  chk_full_fetch: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && fetch_q == FETCH_IDLE && fetch_req && !status_q[ST_PROGRAM_WIDTH_PIN_BIT])
    |=> fetch_done && fetch_word == $past(fetch_rdata32))
    else $error("32-bit fetch wrong");
  chk_io_two: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && !io_busy_q && dec_d.io) |=> mem_dec.io ##1 mem_dec.io)
    else $error("io strobe not two cycles");
  chk_rx_route: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && serial_rx_irq && ie_q[IE_DMA1_LSB + IF_RX_BIT])
    |=> dma1_serial_rx_req)
    else $error("rx not routed to dma 1");
  chk_level_mode: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && !edge_mode && ext_act[0]) |=> if_q[IF_INT0_BIT])
    else $error("level line not flagged");
  chk_flag_set_wins: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && dma0_done_irq) |=> if_q[IF_DMA0_BIT])
    else $error("dma 0 done flag lost");

endmodule // interrupt_vector_config
`default_nettype wire

// ===== include/ivc_pkg.sv
// package for the interrupt and vector configuration block
// assumes a 24-bit word address space and a 32-bit cpu register port
package ivc_pkg;
  // register indices on the plain register port (offsets chosen)
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_IRQ_ENABLE = 2'h1;
  localparam logic [1:0] ADDR_IRQ_FLAG = 2'h2;
  localparam logic [1:0] ADDR_VECTOR_BASE = 2'h3;
  // status field positions
  localparam int ST_EDGE_BIT = 14;
  localparam int ST_PROGRAM_WIDTH_PIN_BIT = 15;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_WMASK = 32'h0000_7FFF;
  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_FLAG_RESET = 32'h0000_0000;
  // irq flag layout: sources in low bits, table pointer in the upper 16 bits
  localparam int IF_INT0_BIT = 0;
  localparam int IF_TX_BIT = 4;
  localparam int IF_RX_BIT = 5;
  localparam int IF_TMR0_BIT = 8;
  localparam int IF_TMR1_BIT = 9;
  localparam int IF_DMA0_BIT = 10;
  localparam int IF_DMA1_BIT = 11;
  localparam int IF_PTR_LSB = 16;
  localparam int PTR_W = 16;
  localparam int VEC_SHIFT = 8;
  localparam int SRC_N = 8;
  localparam int NUM_EXT = 4;
  // enable layout: dma channel 0 enables at 16, channel 1 at 24
  localparam int IE_DMA0_LSB = 16;
  localparam int IE_DMA1_LSB = 24;
  // vector offsets, one per source in flag order
  localparam logic [7:0] VOFF_INT0 = 8'h01;
  localparam logic [7:0] VOFF_TX = 8'h05;
  localparam logic [7:0] VOFF_RX = 8'h06;
  localparam logic [7:0] VOFF_TMR0 = 8'h09;
  localparam logic [7:0] VOFF_TMR1 = 8'h0A;
  localparam logic [7:0] VOFF_DMA0 = 8'h0B;
  localparam logic [7:0] VOFF_DMA1 = 8'h0C;
  localparam logic [7:0] VOFF_TRAP = 8'h20;
  localparam logic [23:0] RESET_VECTOR = 24'h00_0000;
  // edge mode: line must stay active this long after its edge
  localparam int EDGE_HOLD_NS = 100;
  localparam int CLK_NS = 50;
  localparam int EDGE_HOLD_CYC = (EDGE_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // address map
  localparam logic [23:0] PERIPH_BASE = 24'h80_8000;
  localparam logic [23:0] PERIPH_RSVD_LO = 24'h80_8050;
  localparam logic [23:0] PERIPH_XPORT = 24'h80_8060;
  localparam logic [23:0] PERIPH_RSVD_HI = 24'h80_8070;
  localparam logic [23:0] PERIPH_END = 24'h80_97FF;
  localparam logic [23:0] IO_BASE = 24'h80_4000;
  localparam logic [23:0] IO_END = 24'h80_5FFF;
  localparam logic [23:0] STROBE_ONE_BASE = 24'h88_0000;
  localparam logic [23:0] BOOT_ROM_END = 24'h00_0FFF;
  localparam int IO_CYCLES = 2;
  // strobe control reset values per program width (arbitrary defaults)
  localparam logic [31:0] STRB_CTL_W32 = 32'h000F_0000;
  localparam logic [31:0] STRB_CTL_W16 = 32'h0005_0000;

  typedef enum logic [1:0] {FETCH_IDLE, FETCH_LOW, FETCH_HIGH} fetch_e;
  typedef enum logic [2:0] {REG_NONE, REG_DMA0, REG_DMA1, REG_TMR0,
                            REG_TMR1, REG_SERIAL, REG_XPORT} region_e;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  // external access request to be decoded
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } mem_req_s;

  // decoded strobes
  typedef struct packed {
    logic strobe_zero;
    logic strobe_one;
    logic io;
    logic periph;
    logic reserved;
    region_e region;
  } decode_s;
endpackage

// ===== test/ext_side_model.sv
// far side of the block: external program memory and interrupt sources
// assumes the bench holds fetch_addr steady for the whole fetch
`timescale 1ns/1ps
`default_nettype none
module ext_side_model (
  input wire logic [23:0] fetch_addr,
  input wire logic fetch_half,
  input wire logic [3:0] irq_on,
  output logic [15:0] fetch_rdata,
  output logic [31:0] fetch_rdata32,
  output logic [3:0] external_irq_lines_n
);
  logic [31:0] word;
  // memory content is a fixed function of the address, so halves differ
  assign word = {fetch_addr[15:0] ^ 16'hC3A5, fetch_addr[15:0]};
  assign fetch_rdata32 = word;
  // a 16-bit memory only shows the half that the block asks for
  assign fetch_rdata = fetch_half ? word[31:16] : word[15:0];
  // the pins are active low
  assign external_irq_lines_n = ~irq_on;
endmodule // ext_side_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the interrupt and vector configuration block
// assumes ivc_pkg and the far side model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ivc_pkg::*;
  logic core_clk, rst_n, pw, boot, vreq, vrst, vtrap, freq, ce;
  logic [7:0] pend;
  logic fhalf, fdone, vvalid, tx_req, rx_req;
  logic [5:0] src;
  logic [2:0] vsrc;
  logic [4:0] vnum;
  logic [3:0] irq_on, nlines;
  logic [15:0] frd;
  logic [23:0] vaddr, faddr;
  logic [31:0] rdata, frd32, fword, s0rst, s1rst;
  reg_req_s rq;
  mem_req_s mq;
  decode_s dec;
  int bad_count, n_tests, halves;
  logic [7:0] voff [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
                           8'h05, 8'h06, 8'h09, 8'h0A};
  region_e rg [8] = '{REG_DMA0, REG_DMA1, REG_TMR0, REG_TMR1,
                      REG_SERIAL, REG_NONE, REG_XPORT, REG_NONE};

  interrupt_vector_config i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(ce), .reg_req(rq), .reg_rdata(rdata),
    .external_irq_lines_n(nlines), .serial_tx_irq(src[0]),
    .serial_rx_irq(src[1]), .timer0_irq(src[2]), .timer1_irq(src[3]),
    .dma0_done_irq(src[4]), .dma1_done_irq(src[5]),
    .program_width_pin(pw), .boot_mode_pin(boot), .vec_req(vreq),
    .vec_reset(vrst), .vec_src(vsrc), .vec_trap(vtrap),
    .vec_trap_num(vnum), .vec_addr(vaddr), .vec_valid(vvalid),
    .fetch_req(freq), .fetch_addr(faddr), .fetch_rdata(frd),
    .fetch_rdata32(frd32), .fetch_half(fhalf), .fetch_word(fword),
    .fetch_done(fdone), .mem_req(mq), .mem_dec(dec),
    .strobe_zero_ctl_reset(s0rst), .strobe_one_ctl_reset(s1rst),
    .dma0_serial_tx_req(tx_req), .dma1_serial_rx_req(rx_req),
    .irq_pending(pend));

  ext_side_model i_mem (.fetch_addr(faddr), .fetch_half(fhalf),
    .irq_on(irq_on), .fetch_rdata(frd), .fetch_rdata32(frd32),
    .external_irq_lines_n(nlines));

  // free-running core clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // four-state compare, so an unknown never counts as a match
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  // register port: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    rq <= {1'b1, 1'b0, a, d};
    @(posedge core_clk);
    rq <= '0;
  endtask

  task automatic rc(input string nm, input logic [1:0] a,
                    input logic [31:0] e);
    @(posedge core_clk);
    rq <= {1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge core_clk);
    rq <= '0;
    @(negedge core_clk);
    chk(nm, e, rdata);
    // hand back on a rising edge so the next stimulus lands there
    @(posedge core_clk);
  endtask

  // holds the interrupt sources, then looks after the sampling edge
  task automatic pl(input logic [5:0] v);
    @(posedge core_clk);
    src <= v;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic vec(input logic t, input logic r, input logic [2:0] s,
                     input logic [4:0] n, input logic [23:0] e);
    @(posedge core_clk);
    vreq <= ~r;
    vrst <= r;
    vtrap <= t;
    vsrc <= s;
    vnum <= n;
    @(posedge core_clk);
    vreq <= 1'b0;
    vrst <= 1'b0;
    @(negedge core_clk);
    chk("vec_valid", 32'h0000_0001, {31'h0, vvalid});
    chk("vec_addr", {8'h00, e}, {8'h00, vaddr});
  endtask

  // the wait for completion is bounded; a hang ends the run
  task automatic fetch(input logic [23:0] a, input logic [31:0] e,
                       input logic two);
    int i;
    @(posedge core_clk);
    freq <= 1'b1;
    faddr <= a;
    @(posedge core_clk);
    freq <= 1'b0;
    halves = 0;
    for (i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (fhalf === 1'b1) halves++;
      if (fdone === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      finish_test();
    end
    chk("fetch_word", e, fword);
    chk("fetch_half seen", {31'h0, two}, {31'h0, halves > 0});
    @(posedge core_clk);
  endtask

  // decode fields: strobe_zero strobe_one io periph reserved region, masked
  task automatic dcd(input logic [23:0] a, input logic [7:0] e,
                     input logic [7:0] m);
    @(posedge core_clk);
    mq <= {1'b1, a};
    @(posedge core_clk);
    mq <= '0;
    @(negedge core_clk);
    chk("mem_dec", {24'h0, e & m}, {24'h0, dec & m});
    if (e[5]) begin
      @(negedge core_clk);
      chk("mem_dec io second cycle", 32'h0000_0001, {31'h0, dec.io});
    end
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    {rst_n, pw, boot, vreq, vrst, vtrap, freq} = '0;
    {src, vsrc, vnum, irq_on, faddr} = '0;
    ce = 1'b1;
    rq = '0;
    mq = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rc("status reset", ADDR_STATUS, 32'h0000_0000);
    rc("enable reset", ADDR_IRQ_ENABLE, 32'h0000_0000);
    rc("flag reset", ADDR_IRQ_FLAG, 32'h0000_0000);
    chk("strobe_zero ctl w32", STRB_CTL_W32, s0rst);
    wr(ADDR_IRQ_ENABLE, 32'hFFFF_FFFF);
    rc("enable rw", ADDR_IRQ_ENABLE, 32'hFFFF_FFFF);
    wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
    // level mode: a line held active keeps setting its flag
    irq_on <= 4'h1;
    repeat (4) @(posedge core_clk);
    rc("level flag", ADDR_IRQ_FLAG, 32'h0000_0001);
    wr(ADDR_IRQ_FLAG, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    rc("level again", ADDR_IRQ_FLAG, 32'h0000_0001);
    irq_on <= 4'h0;
    wr(ADDR_IRQ_FLAG, 32'h0000_0000);
    rc("flag cleared", ADDR_IRQ_FLAG, 32'h0000_0000);
    // edge mode: a one-cycle blip is too short, a held edge counts
    wr(ADDR_STATUS, 32'h0000_4000);
    rc("edge mode", ADDR_STATUS, 32'h0000_4000);
    @(posedge core_clk);
    irq_on <= 4'h2;
    @(posedge core_clk);
    irq_on <= 4'h0;
    repeat (4) @(posedge core_clk);
    rc("short edge", ADDR_IRQ_FLAG, 32'h0000_0000);
    irq_on <= 4'h2;
    repeat (4) @(posedge core_clk);
    irq_on <= 4'h0;
    repeat (2) @(posedge core_clk);
    rc("held edge", ADDR_IRQ_FLAG, 32'h0000_0002);
    wr(ADDR_IRQ_FLAG, 32'h0000_0000);
    // width flag follows the pin and ignores writes
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rc("width ro low", ADDR_STATUS, 32'h0000_7FFF);
    pw <= 1'b1;
    repeat (3) @(posedge core_clk);
    rc("width high", ADDR_STATUS, 32'h0000_FFFF);
    wr(ADDR_STATUS, 32'h0000_0000);
    rc("width ro high", ADDR_STATUS, 32'h0000_8000);
    chk("strobe_zero ctl w16", STRB_CTL_W16, s0rst);
    chk("strobe_one ctl w16", STRB_CTL_W16, s1rst);
    fetch(24'h00_1234, {16'h1234 ^ 16'hC3A5, 16'h1234}, 1'b1);
    pw <= 1'b0;
    repeat (3) @(posedge core_clk);
    rc("width low", ADDR_STATUS, 32'h0000_0000);
    fetch(24'h00_2468, {16'h2468 ^ 16'hC3A5, 16'h2468}, 1'b0);
    // vector table on a 256-word boundary, all eight vec_src codes and two traps
    wr(ADDR_IRQ_FLAG, 32'h0100_0000);
    for (int k = 0; k < 8; k++) begin
      vec(1'b0, 1'b0, 3'(k), 5'h00, {16'h0100, voff[k]});
    end
    vec(1'b1, 1'b0, 3'h0, 5'h00, 24'h01_0020);
    vec(1'b1, 1'b0, 3'h0, 5'h1F, 24'h01_003F);
    vec(1'b0, 1'b1, 3'h4, 5'h00, 24'h00_0000);
    wr(ADDR_IRQ_FLAG, 32'hFFFF_0000);
    vec(1'b0, 1'b0, 3'h4, 5'h00, 24'hFF_FF05);
    wr(ADDR_VECTOR_BASE, 32'h0000_0000);
    rc("vector base", ADDR_VECTOR_BASE, 32'h00FF_FF00);
    // serial requests are wired to fixed dma channels
    wr(ADDR_IRQ_ENABLE, 32'h2010_0000);
    pl(6'h01);
    chk("tx to dma0", 32'h0000_0001, {31'h0, tx_req});
    chk("tx not dma1", 32'h0000_0000, {31'h0, rx_req});
    pl(6'h02);
    chk("rx to dma1", 32'h0000_0001, {31'h0, rx_req});
    chk("rx not dma0", 32'h0000_0000, {31'h0, tx_req});
    pl(6'h00);
    rc("serial flags", ADDR_IRQ_FLAG, 32'hFFFF_0030);
    wr(ADDR_IRQ_FLAG, 32'h0000_0000);
    pl(6'h10);
    pl(6'h00);
    rc("dma0 flag", ADDR_IRQ_FLAG, 32'h0000_0400);
    pl(6'h2C);
    pl(6'h00);
    rc("dma1 flag", ADDR_IRQ_FLAG, 32'h0000_0F00);
    // timer and dma flags enabled: their four pending bits rise
    wr(ADDR_IRQ_ENABLE, 32'h0000_0F00);
    pl(6'h00);
    chk("irq pending", 32'h0000_00F0, {24'h0, pend});
    // address decode: strobes, io hold, boot map, peripheral regions
    dcd(24'h00_1000, 8'h80, 8'hE0);
    dcd(STROBE_ONE_BASE, 8'h40, 8'hE0);
    dcd(IO_BASE, 8'h20, 8'hE0);
    boot <= 1'b1;
    dcd(24'h00_0100, 8'h00, 8'hE0);
    boot <= 1'b0;
    dcd(24'h00_0100, 8'h80, 8'hE0);
    for (int k = 0; k < 8; k++) begin
      if (k == 5 || k == 7) begin
        dcd(PERIPH_BASE + 24'(16 * k), {5'b00001, rg[k]}, 8'h0F);
      end else begin
        dcd(PERIPH_BASE + 24'(16 * k), {5'b00010, rg[k]}, 8'h1F);
      end
    end
    dcd(PERIPH_END, {5'b00001, REG_NONE}, 8'h0F);
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
    ce <= 1'b1;
    rc("enable frozen", ADDR_IRQ_ENABLE, 32'h0000_0F00);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
